//--- logic/nia_pkg.sv
// constants and carrier types shared by the network interrupt aggregator
package nia_pkg;

  // ****************************************
  // host bus geometry
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int CHAN_N = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 10'h002;
  localparam logic [ADDR_W-1:0] OFS_MASK  = 10'h004;

  // ****************************************
  // field positions and groups
  // ****************************************
  localparam int BIT_ADDR_CONFLICT = 15;
  localparam int BIT_PORT_UNREACH  = 14;
  localparam int BIT_SESSION_TERM  = 13;
  localparam int BIT_FRAG_SIZE     = 12;
  localparam int CHAN_LSB          = 0;

  localparam logic [DATA_W-1:0] GLOBAL_BITS   = 16'hF000;
  localparam logic [DATA_W-1:0] RESERVED_BITS = 16'h0F00;
  localparam logic [DATA_W-1:0] CHANNEL_BITS  = 16'h00FF;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [DATA_W-1:0] RESET_FLAGS = 16'h0000;
  localparam logic [DATA_W-1:0] RESET_MASK  = 16'h0000;
  localparam logic [DATA_W-1:0] IDLE_READ   = 16'h0000;

  // ****************************************
  // synchroniser depth and pin idle levels
  // ****************************************
  localparam int SYNC_STAGES = 3;

  // global event pulses from the protocol engines
  typedef struct packed {
    logic port_unreach;   // icmp destination port unreachable seen
    logic session_closed; // pppoe session with server closed
    logic frag_size;      // icmp fragmentation needed with path mtu
  } nia_global_evt_t;

  // host bus pins after synchronising
  typedef struct packed {
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nia_host_pins_t;

  localparam int HOST_PINS_W = 3 + ADDR_W + DATA_W;
  localparam logic [HOST_PINS_W-1:0] HOST_PINS_IDLE = {3'h7, 10'h000, 16'h0000};

endpackage

//--- logic/nia_pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module nia_pin_sync #(
  parameter int               WIDTH    = 1,
  parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
  input  wire logic             clk,     // device clock
  input  wire logic             reset,   // asynchronous, active high
  input  wire logic [WIDTH-1:0] pin_in,  // asynchronous pins
  output logic      [WIDTH-1:0] pin_out  // settled synchronous value
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_out;

  // per bit, take the new level only when the last two stages match
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_out[i];
    end
  end

  // stage1 feeds stage2 only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1  <= IDLE_VAL;
      stage2  <= IDLE_VAL;
      stage3  <= IDLE_VAL;
      pin_out <= IDLE_VAL;
    end else begin
      stage1  <= pin_in;
      stage2  <= stage1;
      stage3  <= stage2;
      pin_out <= next_out;
    end
  end

endmodule // nia_pin_sync

//--- logic/nia_aggregator.sv
// network interrupt aggregator: flag and mask registers, host bus slave and interrupt pin
`timescale 1ns/1ps

module nia_aggregator
  import nia_pkg::*;
#(
  parameter int CHANNELS = CHAN_N
) (
  input  wire logic                clk,                 // 200 MHz device clock
  input  wire logic                reset,               // asynchronous, active high
  // host parallel bus pins
  input  wire logic                host_cs_n,           // chip select, active low
  input  wire logic                host_rd_n,           // read strobe, active low
  input  wire logic                host_wr_n,           // write strobe, active low
  input  wire logic [ADDR_W-1:0]   host_addr,           // byte address
  input  wire logic [DATA_W-1:0]   host_data_in,        // data pin input side
  output logic      [DATA_W-1:0]   host_data_out,       // data pin output side
  output logic                     host_data_oe_n,      // low while driving data pins
  output logic                     host_int_n,          // interrupt request, active low
  // protocol engine events, same clock
  input  wire logic                arp_request_seen,    // arp request received, pulse
  input  wire logic [31:0]         arp_sender_ip,       // sender protocol address of it
  input  wire logic [31:0]         source_ip,           // own configured source address
  input  wire logic                pppoe_mode,          // pppoe mode enabled, level
  input  wire nia_global_evt_t     global_evt,          // other global event pulses
  input  wire logic [CHANNELS-1:0] channel_event,       // channel raised interrupt, pulse
  input  wire logic [CHANNELS-1:0] channel_flags_clear, // channel flags now 0x00, pulse
  // visibility
  output logic      [DATA_W-1:0]   interrupt_flags_out, // current flag register
  output logic      [DATA_W-1:0]   interrupt_mask_out   // current mask register
);

  // ****************************************
  // host pin synchronisation
  // ****************************************

  // raw and synchronised host pins
  nia_host_pins_t host_raw;
  nia_host_pins_t host_sync;
  logic [HOST_PINS_W-1:0] host_sync_bits;

  // bundle the pins for the synchroniser
  assign host_raw.cs_n  = host_cs_n;
  assign host_raw.rd_n  = host_rd_n;
  assign host_raw.wr_n  = host_wr_n;
  assign host_raw.addr  = host_addr;
  assign host_raw.wdata = host_data_in;
  assign host_sync      = nia_host_pins_t'(host_sync_bits);

  nia_pin_sync #(
    .WIDTH    (HOST_PINS_W),
    .IDLE_VAL (HOST_PINS_IDLE)
  ) u_host_sync (
    .clk     (clk),
    .reset   (reset),
    .pin_in  (host_raw),
    .pin_out (host_sync_bits)
  );

  // ****************************************
  // host cycle tracking
  // ****************************************

  // one host access at a time: a write window, a read window or nothing
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } nia_bus_state_t;

  nia_bus_state_t    bus_state;      // access now in progress
  nia_bus_state_t    next_bus_state;
  logic              wr_active;      // synced write strobe window
  logic              rd_active;      // synced read strobe window
  logic              rd_start;       // first cycle of a read window
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;
  logic              wr_commit;      // write lands in this cycle

  assign wr_active = ~host_sync.cs_n & ~host_sync.wr_n;
  assign rd_active = ~host_sync.cs_n & ~host_sync.rd_n;

  // a write takes effect once, when its window closes, with the last address and data
  // seen inside it; a read strobe is answered only once no write window is open, and a write strobe inside a read window is dropped
  always_comb begin
    next_bus_state = bus_state;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    wr_commit      = 1'b0;
    rd_start       = 1'b0;
    case (bus_state)
      BUS_IDLE: begin
        if (wr_active) begin
          next_bus_state = BUS_WRITE;
          next_wr_addr   = host_sync.addr;
          next_wr_data   = host_sync.wdata;
        end else if (rd_active) begin
          next_bus_state = BUS_READ;
          rd_start       = 1'b1;
        end
      end
      BUS_WRITE: begin
        if (wr_active) begin
          next_wr_addr = host_sync.addr;
          next_wr_data = host_sync.wdata;
        end else begin
          next_bus_state = BUS_IDLE;
          wr_commit      = 1'b1;
        end
      end
      BUS_READ: begin
        if (!rd_active) begin
          next_bus_state = BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_state <= BUS_IDLE;
      wr_addr   <= '0;
      wr_data   <= '0;
    end else begin
      bus_state <= next_bus_state;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
    end
  end

  // ****************************************
  // event decode
  // ****************************************

  // decoded hardware events
  logic [DATA_W-1:0] set_bits;
  logic              addr_conflict;
  logic              session_end;

  // address conflict: arp request from someone using our address
  assign addr_conflict = arp_request_seen & (arp_sender_ip == source_ip);

  // a closed session only counts while pppoe mode is on
  assign session_end = global_evt.session_closed & pppoe_mode;

  // one set vector gathering every hardware event
  always_comb begin
    set_bits                    = '0;
    set_bits[BIT_ADDR_CONFLICT] = addr_conflict;
    set_bits[BIT_PORT_UNREACH]  = global_evt.port_unreach;
    set_bits[BIT_SESSION_TERM]  = session_end;
    set_bits[BIT_FRAG_SIZE]     = global_evt.frag_size;
    set_bits[CHAN_LSB +: CHANNELS] = channel_event;
  end

  // ****************************************
  // flag and mask registers
  // ****************************************

  // register state and its next values
  logic [DATA_W-1:0] interrupt_flags;
  logic [DATA_W-1:0] interrupt_mask;
  logic [DATA_W-1:0] next_flags;
  logic [DATA_W-1:0] next_mask;
  logic [DATA_W-1:0] clear_bits;

  // true for the one cycle in which a write to the given offset lands
  function automatic logic reg_hit(input logic commit,
                                   input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    reg_hit = commit && (addr == offset);
  endfunction

  // write-one-to-clear for the global group only, decoded at the flags offset
  function automatic logic [DATA_W-1:0] host_clear(input logic commit,
                                                   input logic [ADDR_W-1:0] addr,
                                                   input logic [DATA_W-1:0] data);
    host_clear = reg_hit(commit, addr, OFS_FLAGS) ? (data & GLOBAL_BITS) : '0;
  endfunction

  // clear sources: host ones on global bits, channel auto clear on low byte
  always_comb begin
    clear_bits = host_clear(wr_commit, wr_addr, wr_data);
    clear_bits[CHAN_LSB +: CHANNELS] = channel_flags_clear;
  end

  // set wins over clear in the same cycle, reserved bits held at zero
  always_comb begin
    next_flags = ((interrupt_flags & ~clear_bits) | set_bits) & ~RESERVED_BITS;
    next_mask  = interrupt_mask;
    if (reg_hit(wr_commit, wr_addr, OFS_MASK)) begin
      next_mask = wr_data & ~RESERVED_BITS;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_flags <= RESET_FLAGS;
      interrupt_mask  <= RESET_MASK;
    end else begin
      interrupt_flags <= next_flags;
      interrupt_mask  <= next_mask;
    end
  end

  assign interrupt_flags_out = interrupt_flags;
  assign interrupt_mask_out  = interrupt_mask;

  // ****************************************
  // interrupt request pin
  // ****************************************

  // pin state and the two conditions that move it
  logic int_req;
  logic next_int_req;
  logic masked_any;
  logic all_flags_clear;

  assign masked_any      = |(interrupt_flags & interrupt_mask);
  assign all_flags_clear = (interrupt_flags == '0);

  // raise on a masked flag, then hold until every flag reads zero
  always_comb begin
    next_int_req = int_req;
    if (masked_any) begin
      next_int_req = 1'b1;
    end else if (all_flags_clear) begin
      next_int_req = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_req <= 1'b0;
    end else begin
      int_req <= next_int_req;
    end
  end

  assign host_int_n = ~int_req;

  // ****************************************
  // host read path
  // ****************************************

  // next read outputs
  logic [DATA_W-1:0] next_data_out;
  logic              next_data_oe_n;

  // register read map, unmapped offsets read zero
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr,
                                                  input logic [DATA_W-1:0] flags,
                                                  input logic [DATA_W-1:0] mask);
    case (addr)
      OFS_FLAGS: read_word = flags & ~RESERVED_BITS;
      OFS_MASK:  read_word = mask & ~RESERVED_BITS;
      default:   read_word = IDLE_READ;
    endcase
  endfunction

  // take the word as the read window opens and let it stand, so a flag set
  // mid-read cannot change the data under the host's strobe
  always_comb begin
    next_data_out  = host_data_out;
    next_data_oe_n = host_data_oe_n;
    if (rd_start) begin
      next_data_out  = read_word(host_sync.addr, interrupt_flags, interrupt_mask);
      next_data_oe_n = 1'b0;
    end else if (!rd_active || bus_state != BUS_READ) begin
      next_data_out  = IDLE_READ;
      next_data_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_data_out  <= IDLE_READ;
      host_data_oe_n <= 1'b1;
    end else begin
      host_data_out  <= next_data_out;
      host_data_oe_n <= next_data_oe_n;
    end
  end

endmodule // nia_aggregator

//--- verification/nia_assertions.sv
// port relations of the interrupt aggregator
`timescale 1ns/1ps
module nia_assertions
  import nia_pkg::*;
#(
  parameter int CHANNELS = CHAN_N
) (
  input wire logic                clk,                 // device clock
  input wire logic                reset,               // asynchronous, active high
  input wire logic                host_int_n,          // interrupt request, active low
  input wire logic                arp_request_seen,    // arp request pulse
  input wire logic [31:0]         arp_sender_ip,       // sender address of it
  input wire logic [31:0]         source_ip,           // own configured address
  input wire logic                pppoe_mode,          // pppoe mode level
  input wire nia_global_evt_t     global_evt,          // other global event pulses
  input wire logic [CHANNELS-1:0] channel_event,       // channel event pulses
  input wire logic [CHANNELS-1:0] channel_flags_clear, // channel auto clear pulses
  input wire logic [DATA_W-1:0]   interrupt_flags_out, // flag register
  input wire logic [DATA_W-1:0]   interrupt_mask_out   // mask register
);
  // ****************************************
  // flag and pin relations
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_cset;
    |channel_event |=> (interrupt_flags_out[CHANNELS-1:0] & $past(channel_event)) == $past(channel_event);
  endproperty
  a_cset: assert property (p_cset) else $error("channel flag not set");
  property p_cclr;
    |(channel_flags_clear & ~channel_event) |=>
      (interrupt_flags_out[CHANNELS-1:0] & $past(channel_flags_clear) & ~$past(channel_event)) == '0;
  endproperty
  a_cclr: assert property (p_cclr) else $error("channel flag not cleared");
  property p_chold;
    channel_event == '0 && channel_flags_clear == '0 |=> $stable(interrupt_flags_out[CHANNELS-1:0]);
  endproperty
  a_chold: assert property (p_chold) else $error("channel flag moved");
  property p_arp;
    arp_request_seen && arp_sender_ip == source_ip |=> interrupt_flags_out[BIT_ADDR_CONFLICT];
  endproperty
  a_arp: assert property (p_arp) else $error("conflict flag not set");
  property p_ppp;
    global_evt.session_closed && pppoe_mode |=> interrupt_flags_out[BIT_SESSION_TERM];
  endproperty
  a_ppp: assert property (p_ppp) else $error("session flag not set");
  property p_low;
    (interrupt_flags_out & interrupt_mask_out) != '0 |=> !host_int_n;
  endproperty
  a_low: assert property (p_low) else $error("irq not low");
  property p_high;
    interrupt_flags_out == '0 |=> host_int_n;
  endproperty
  a_high: assert property (p_high) else $error("irq not high");
  property p_hold;
    !host_int_n && interrupt_flags_out != '0 |=> !host_int_n;
  endproperty
  a_hold: assert property (p_hold) else $error("irq left early");
  property p_rsvd;
    ((interrupt_flags_out | interrupt_mask_out) & RESERVED_BITS) == '0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_port_unreachable_flag;
    global_evt.port_unreach |=> interrupt_flags_out[BIT_PORT_UNREACH];
  endproperty
  a_port_unreachable_flag: assert property (p_port_unreachable_flag) else $error("unreachable flag not set");
  property p_frag;
    global_evt.frag_size |=> interrupt_flags_out[BIT_FRAG_SIZE];
  endproperty
  a_frag: assert property (p_frag) else $error("fragment flag not set");
  property p_gate;
    (interrupt_flags_out & interrupt_mask_out) == '0 && host_int_n |=> host_int_n;
  endproperty
  a_gate: assert property (p_gate) else $error("irq without masked flag");
  property p_arp_other;
    arp_request_seen && arp_sender_ip != source_ip && !interrupt_flags_out[BIT_ADDR_CONFLICT] |=>
      !interrupt_flags_out[BIT_ADDR_CONFLICT];
  endproperty
  a_arp_other: assert property (p_arp_other) else $error("conflict flag from other address");
  property p_ppp_off;
    global_evt.session_closed && !pppoe_mode && !interrupt_flags_out[BIT_SESSION_TERM] |=>
      !interrupt_flags_out[BIT_SESSION_TERM];
  endproperty
  a_ppp_off: assert property (p_ppp_off) else $error("session flag outside pppoe mode");
endmodule // nia_assertions

bind nia_aggregator nia_assertions #(.CHANNELS(CHANNELS)) nia_assertions_inst (
  .clk(clk), .reset(reset), .host_int_n(host_int_n), .arp_request_seen(arp_request_seen),
  .arp_sender_ip(arp_sender_ip), .source_ip(source_ip), .pppoe_mode(pppoe_mode),
  .global_evt(global_evt), .channel_event(channel_event), .channel_flags_clear(channel_flags_clear),
  .interrupt_flags_out(interrupt_flags_out), .interrupt_mask_out(interrupt_mask_out));

//--- verification/nia_host_model.sv
// host processor model on the parallel bus
`timescale 1ns/1ps
module nia_host_model
  import nia_pkg::*;
(
  input  wire logic              clk,   // clock
  input  wire logic              oe_n,  // device drives data
  input  wire logic [DATA_W-1:0] rdata, // read data
  output logic                   cs_n,  // chip select
  output logic                   rd_n,  // read strobe
  output logic                   wr_n,  // write strobe
  output logic      [ADDR_W-1:0] addr,  // address
  output logic      [DATA_W-1:0] wdata  // write data
);
  initial {cs_n, rd_n, wr_n, addr, wdata} = HOST_PINS_IDLE;
  // release strobes, then flip stale lines and keep the gap
  task automatic idle();
    {cs_n, rd_n, wr_n} = 3'h7;
    @(posedge clk);
    #1;
    addr = ~addr;
    wdata = ~wdata;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // word write, strobe held four cycles; ones clear global flags
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr = a;
    wdata = d;
    {cs_n, wr_n} = 2'h0;
    repeat (4) @(posedge clk);
    #1;
    idle();
  endtask
  // word read, data taken at the edge the device drives
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    addr = a;
    {cs_n, rd_n} = 2'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (oe_n !== 1'b0 && n < 12);
    // an unanswered read leaves the data lines floating
    d = (oe_n === 1'b0) ? rdata : 'x;
    #1;
    idle();
  endtask
endmodule // nia_host_model

//--- verification/test_nia_aggregator.sv
// self-checking bench of the interrupt aggregator
`timescale 1ns/1ps
module test_nia_aggregator
  import nia_pkg::*;
;
  logic            clk = 1'b0, reset = 1'b1, arp_seen = 1'b0, ppp = 1'b0;
  logic            cs_n, rd_n, wr_n, oe_n, int_n;
  logic [31:0]     arp_ip = 32'h0A000004, own_ip = 32'h0A000005;
  nia_global_evt_t gev = '0;
  logic [7:0]      cev = '0, cclr = '0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, din, dout, flags, mask, rv, irq;
  int              n_errors = 0, samples_checked = 0, cycles = 0;
  assign din = oe_n ? wdata : dout;
  assign irq = {15'h0000, int_n};
  always #2.5 clk = ~clk;
  nia_aggregator nia_aggregator_inst (.clk(clk), .reset(reset), .host_cs_n(cs_n), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .host_addr(addr), .host_data_in(din), .host_data_out(dout), .host_data_oe_n(oe_n),
    .host_int_n(int_n), .arp_request_seen(arp_seen), .arp_sender_ip(arp_ip), .source_ip(own_ip),
    .pppoe_mode(ppp), .global_evt(gev), .channel_event(cev), .channel_flags_clear(cclr),
    .interrupt_flags_out(flags), .interrupt_mask_out(mask));
  nia_host_model nia_host_model_inst (.clk(clk), .oe_n(oe_n), .rdata(dout), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .wdata(wdata));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    nia_host_model_inst.rd(a, rv);
    check(rv, exp);
    check({15'h0000, oe_n}, 16'h0001);
  endtask
  task automatic pulse(input logic a, input nia_global_evt_t g, input logic [7:0] ev, input logic [7:0] cl);
    arp_seen = a;
    gev = g;
    cev = ev;
    cclr = cl;
    tick(1);
    {arp_seen, gev, cev, cclr} = '0;
    tick(2);
  endtask
  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(flags, RESET_FLAGS);
    check(mask | irq, 16'h0001);
    rdchk(OFS_FLAGS, 16'h0000);
    nia_host_model_inst.wr(OFS_MASK, 16'hFFFF);
    rdchk(OFS_MASK, 16'hF0FF);
    rdchk(10'h006, IDLE_READ);
  endtask
  task automatic t_global();
    pulse(1'b1, 3'b010, 8'h00, 8'h00);
    check(flags | irq, 16'h0001);
    arp_ip = own_ip;
    ppp = 1'b1;
    pulse(1'b1, 3'b000, 8'h00, 8'h00);
    check(flags, 16'h8000);
    pulse(1'b0, 3'b100, 8'h00, 8'h00);
    check(flags, 16'hC000);
    pulse(1'b0, 3'b010, 8'h00, 8'h00);
    check(flags, 16'hE000);
    pulse(1'b0, 3'b001, 8'h00, 8'h00);
    check(flags | irq, 16'hF000);
    nia_host_model_inst.wr(OFS_FLAGS, 16'h8F00);
    rdchk(OFS_FLAGS, 16'h7000);
    nia_host_model_inst.wr(OFS_FLAGS, 16'h7000);
    check(flags | irq, 16'h0001);
  endtask
  task automatic t_chan();
    for (int i = 0; i < 8; i++) begin
      pulse(1'b0, 3'b000, 8'h01 << i, 8'h00);
      check(flags, (16'h0002 << i) - 16'h0001);
    end
    nia_host_model_inst.wr(OFS_FLAGS, 16'h00FF);
    check(flags, 16'h00FF);
    pulse(1'b0, 3'b000, 8'h00, 8'h7F);
    nia_host_model_inst.wr(OFS_MASK, 16'h0000);
    check(flags | irq, 16'h0080);
    pulse(1'b0, 3'b000, 8'h00, 8'h80);
    check(flags | irq, 16'h0001);
    pulse(1'b0, 3'b000, 8'h04, 8'h00);
    check(irq, 16'h0001);
    nia_host_model_inst.wr(OFS_MASK, 16'h0004);
    check(irq, 16'h0000);
  endtask
  // reset in mid-run with flags, mask and pin all active
  task automatic t_rst();
    pulse(1'b0, 3'b100, 8'h10, 8'h00);
    nia_host_model_inst.wr(OFS_MASK, 16'hFFFF);
    check(flags | irq, 16'h4014);
    reset = 1'b1;
    tick(2);
    check(flags | mask | irq, 16'h0001);
    reset = 1'b0;
    tick(4);
    rdchk(OFS_FLAGS, RESET_FLAGS);
    rdchk(OFS_MASK, RESET_MASK);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    tick(16);
    reset = 1'b0;
    tick(4);
    t_reset();
    t_global();
    t_chan();
    t_rst();
    conclude();
  end
endmodule // test_nia_aggregator
